// ---- design/onchip_ram_and_icache.sv ----
// Summary of operation
// RULE_01 - Sixteen thousand 16-bit words of RAM are kept in four banks of 4K words.
// RULE_02 - Every bank completes two accesses of any read/write mix in one cycle.
// RULE_03 - Bytes 0x0000-0x7FFF are served, split into four 8K-byte banks in ascending order.
// RULE_04 - Program, data and DMA requesters all reach the RAM.
// RULE_05 - Host-side port accesses are refused while the device is in reset.
// RULE_06 - The first 192 bytes of bank zero belong to the mapped register area and store nothing.
// RULE_07 - One 16K-byte two-way set-associative instruction cache is provided.
// RULE_08 - 512 sets of two lines of four 32-bit words split the address into offset, set and tag.
// RULE_09 - A hit needs a valid line in the set whose stored tag equals the fetch tag.
// RULE_10 - Misses replace the least recently used line, updated on each access to the set; the code skips the update on hits while the cache is frozen.
// RULE_11 - Enable, freeze and flush bits of the status word steer the cache.
// RULE_12 - Fetched external instructions are kept and later fetches are served from the cache.
// RULE_13 - A frozen cache serves hits but forwards misses without touching any line.
// RULE_14 - Flush clears every valid bit in both ways; a line completing in the flush cycle is left valid.
module onchip_ram_and_icache
    import onchip_mem_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              device_in_reset_in,
    // RAM requester A
    input  wire logic              a_req_in,
    input  wire logic              a_we_in,
    input  wire src_t              a_src_in,
    input  wire logic [ADDR_W-1:0] a_addr_in,
    input  wire logic [RAM_DW-1:0] a_wdata_in,
    output logic      [RAM_DW-1:0] a_rdata_out,
    output logic                   a_ack_out,
    output logic                   a_err_out,
    // RAM requester B
    input  wire logic              b_req_in,
    input  wire logic              b_we_in,
    input  wire src_t              b_src_in,
    input  wire logic [ADDR_W-1:0] b_addr_in,
    input  wire logic [RAM_DW-1:0] b_wdata_in,
    output logic      [RAM_DW-1:0] b_rdata_out,
    output logic                   b_ack_out,
    output logic                   b_err_out,
    // Cache control bits of cpu_status_word_three
    input  wire logic              cache_enable_in,
    input  wire logic              cache_freeze_in,
    input  wire logic              cache_flush_in,
    // Instruction fetch
    input  wire logic              fetch_req_in,
    input  wire logic [ADDR_W-1:0] fetch_addr_in,
    output logic                   fetch_busy_out,
    output logic                   fetch_done_out,
    output logic    [CACHE_DW-1:0] fetch_data_out,
    // External memory
    output logic                   ext_req_out,
    output logic      [ADDR_W-1:0] ext_addr_out,
    input  wire logic              ext_valid_in,
    input  wire logic [CACHE_DW-1:0] ext_data_in
);
    // Dual-access RAM
    logic              p_req   [2];
    logic              p_we    [2];
    src_t              p_src   [2];
    logic [ADDR_W-1:0] p_addr  [2];
    logic [RAM_DW-1:0] p_wdata [2];
    logic              p_ok    [2];
    logic              p_bad   [2];
    logic [BANK_SEL_W-1:0] p_bank [2];
    logic [BANK_SEL_W-1:0] rd_bank [2];
    logic [BANK_SEL_W-1:0] next_rd_bank [2];
    logic [RAM_DW-1:0] bank_rd [BANK_COUNT][2];
    logic [1:0] ack, next_ack, err, next_err;

    assign p_req[0] = a_req_in;
    assign p_req[1] = b_req_in;
    assign p_we[0] = a_we_in;
    assign p_we[1] = b_we_in;
    assign p_src[0] = a_src_in;
    assign p_src[1] = b_src_in;
    assign p_addr[0] = a_addr_in;
    assign p_addr[1] = b_addr_in;
    assign p_wdata[0] = a_wdata_in;
    assign p_wdata[1] = b_wdata_in;

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            // RULE_05 host held off in reset
            // RULE_03 decoded range
            // RULE_06 mapped register area
            p_bad[p] = (p_src[p] == SRC_HOST && (device_in_reset_in || reset_in))
                || p_addr[p] >= RAM_TOP_BYTE || p_addr[p] < MAPPED_REG_END;
            // RULE_04 any bus may request
            p_ok[p] = p_req[p] && !p_bad[p];
            p_bank[p] = p_addr[p][BANK_SEL_LSB +: BANK_SEL_W];
            next_ack[p] = p_ok[p];
            next_err[p] = p_req[p] && p_bad[p];
            next_rd_bank[p] = p_ok[p] ? p_bank[p] : rd_bank[p];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ack <= 2'h0;
            err <= 2'h0;
            rd_bank[0] <= '0;
            rd_bank[1] <= '0;
        end
        else
        begin
            ack <= next_ack;
            err <= next_err;
            rd_bank[0] <= next_rd_bank[0];
            rd_bank[1] <= next_rd_bank[1];
        end
    end

    // RULE_01 four 4K banks
    // RULE_02 two accesses per bank per cycle
    for (genvar g = 0; g < BANK_COUNT; g++)
    begin : g_bank
        dual_port_mem #(.DW(RAM_DW), .AW(BANK_AW)) u_bank (
            .clk_in     (clk_in),
            .a_en_in    (p_ok[0] && p_bank[0] == BANK_SEL_W'(g)),
            .a_we_in    (p_we[0]),
            .a_addr_in  (p_addr[0][WORD_LSB +: BANK_AW]),
            .a_wdata_in (p_wdata[0]),
            .a_rdata_out(bank_rd[g][0]),
            .b_en_in    (p_ok[1] && p_bank[1] == BANK_SEL_W'(g)),
            .b_we_in    (p_we[1]),
            .b_addr_in  (p_addr[1][WORD_LSB +: BANK_AW]),
            .b_wdata_in (p_wdata[1]),
            .b_rdata_out(bank_rd[g][1])
        );
    end

    assign a_rdata_out = bank_rd[rd_bank[0]][0];
    assign b_rdata_out = bank_rd[rd_bank[1]][1];
    assign a_ack_out = ack[0];
    assign b_ack_out = ack[1];
    assign a_err_out = err[0];
    assign b_err_out = err[1];

    // Instruction cache
    cache_state_t state, next_state;
    logic [ADDR_W-1:0]     fa, next_fa;
    logic [WORD_SEL_W-1:0] cnt, next_cnt;
    logic                  victim, next_victim;
    logic                  done, next_done;
    logic [CACHE_DW-1:0]   fdata, next_fdata;
    logic [(2**SET_AW)-1:0] valid [WAY_COUNT];
    logic [(2**SET_AW)-1:0] lru;
    logic [TAG_W-1:0]      tag_rd [WAY_COUNT];
    logic [CACHE_DW-1:0]   data_rd [WAY_COUNT];
    logic [WAY_COUNT-1:0]  hit;
    logic                  set_we, lru_we, lru_val;
    logic [SET_AW-1:0]     idx;
    logic                  rd_en, data_we, tag_we;

    // RULE_08 address split
    assign idx = fa[SET_LSB +: SET_AW];

    always_comb
    begin
        // RULE_09 tag compare on valid lines
        for (int w = 0; w < WAY_COUNT; w++)
            hit[w] = valid[w][idx] && tag_rd[w] == fa[TAG_LSB +: TAG_W];
        next_state = state;
        next_fa = fa;
        next_cnt = cnt;
        next_victim = victim;
        next_done = 1'b0;
        next_fdata = fdata;
        set_we = 1'b0;
        lru_we = 1'b0;
        lru_val = 1'b0;
        rd_en = 1'b0;
        data_we = 1'b0;
        tag_we = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (fetch_req_in)
                begin
                    next_fa = fetch_addr_in;
                    rd_en = 1'b1;
                    // RULE_11 enable bit gates caching
                    next_state = cache_enable_in ? ST_LOOKUP : ST_BYPASS;
                end
            end
            ST_LOOKUP:
            begin
                if (hit != 2'h0)
                begin
                    // RULE_12 served from storage
                    next_fdata = hit[1] ? data_rd[1] : data_rd[0];
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                    // RULE_10 hit way becomes most recent unless frozen
                    lru_we = !cache_freeze_in;
                    lru_val = !hit[1];
                end
                // RULE_13 frozen misses bypass
                else if (cache_freeze_in)
                    next_state = ST_BYPASS;
                else
                begin
                    // RULE_10 empty way first, else LRU
                    next_victim = !valid[0][idx] ? 1'b0 : (!valid[1][idx] ? 1'b1 : lru[idx]);
                    next_cnt = '0;
                    next_state = ST_FILL;
                end
            end
            ST_FILL:
            begin
                if (ext_valid_in)
                begin
                    data_we = 1'b1;
                    next_cnt = cnt + 1'b1;
                    if (cnt == fa[WORD_SEL_LSB +: WORD_SEL_W])
                        next_fdata = ext_data_in;
                    if (cnt == LAST_WORD)
                    begin
                        tag_we = 1'b1;
                        set_we = 1'b1;
                        lru_we = 1'b1;
                        lru_val = !victim;
                        next_done = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_BYPASS:
            begin
                if (ext_valid_in)
                begin
                    next_fdata = ext_data_in;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state <= ST_IDLE;
            fa <= '0;
            cnt <= '0;
            victim <= 1'b0;
            done <= 1'b0;
            fdata <= '0;
            valid[0] <= '0;
            valid[1] <= '0;
            lru <= '0;
        end
        else
        begin
            state <= next_state;
            fa <= next_fa;
            cnt <= next_cnt;
            victim <= next_victim;
            done <= next_done;
            fdata <= next_fdata;
            // RULE_14 flush clears both ways
            // RULE_11 flush bit
            if (cache_flush_in)
            begin
                valid[0] <= '0;
                valid[1] <= '0;
            end
            else if (state == ST_FILL && cnt == '0 && ext_valid_in)
                valid[victim][idx] <= 1'b0;
            // Completing line wins over a flush in the same cycle
            if (set_we)
                valid[victim][idx] <= 1'b1;
            if (lru_we)
                lru[idx] <= lru_val;
        end
    end

    // RULE_07 two ways of 16K bytes total
    for (genvar w = 0; w < WAY_COUNT; w++)
    begin : g_way
        dual_port_mem #(.DW(CACHE_DW), .AW(LINE_AW)) u_data (
            .clk_in     (clk_in),
            .a_en_in    (rd_en || (data_we && victim == 1'(w))),
            .a_we_in    (data_we),
            .a_addr_in  (rd_en ? fetch_addr_in[SET_LSB-WORD_SEL_W +: LINE_AW] : {idx, cnt}),
            .a_wdata_in (ext_data_in),
            .a_rdata_out(data_rd[w]),
            .b_en_in    (1'b0),
            .b_we_in    (1'b0),
            .b_addr_in  ('0),
            .b_wdata_in ('0),
            .b_rdata_out()
        );
        dual_port_mem #(.DW(TAG_W), .AW(SET_AW)) u_tag (
            .clk_in     (clk_in),
            .a_en_in    (rd_en || (tag_we && victim == 1'(w))),
            .a_we_in    (tag_we),
            .a_addr_in  (rd_en ? fetch_addr_in[SET_LSB +: SET_AW] : idx),
            .a_wdata_in (fa[TAG_LSB +: TAG_W]),
            .a_rdata_out(tag_rd[w]),
            .b_en_in    (1'b0),
            .b_we_in    (1'b0),
            .b_addr_in  ('0),
            .b_wdata_in ('0),
            .b_rdata_out()
        );
    end

    assign fetch_busy_out = state != ST_IDLE;
    assign fetch_done_out = done;
    assign fetch_data_out = fdata;
    assign ext_req_out = state == ST_FILL || state == ST_BYPASS;
    assign ext_addr_out = state == ST_FILL ? {fa[ADDR_W-1:SET_LSB], cnt, 2'h0} : {fa[ADDR_W-1:2], 2'h0};

    // Checks
    chk_ack_next_cycle: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_02
        p_ok[0] && p_ok[1] |=> a_ack_out && b_ack_out && !a_err_out && !b_err_out)
        else $error("granted access not acknowledged next cycle");
    chk_host_reset_refused: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_05
        a_req_in && a_src_in == SRC_HOST && device_in_reset_in |=> a_err_out && !a_ack_out)
        else $error("host access taken during reset");
    chk_mapped_area_refused: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_06
        b_req_in && b_addr_in < MAPPED_REG_END |=> b_err_out && !b_ack_out)
        else $error("mapped register area accepted");
    chk_range_refused: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_03
        a_req_in && a_addr_in >= RAM_TOP_BYTE |=> a_err_out)
        else $error("address above RAM accepted");
    chk_write_readback: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_01
        p_ok[0] && a_we_in && !(p_ok[1] && b_we_in)
        ##1 p_ok[1] && !b_we_in && !p_ok[0] && b_addr_in[14:1] == $past(a_addr_in[14:1])
        |=> b_rdata_out == $past(a_wdata_in, 2))
        else $error("written word not read back");
    chk_hit_latency: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_09
        state == ST_LOOKUP && hit != 2'h0 |=> fetch_done_out && fetch_data_out == $past(hit[1] ? data_rd[1] : data_rd[0]))
        else $error("hit not served next cycle");
    chk_flush_clears: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_14
        cache_flush_in && !set_we |=> valid[0] == '0 && valid[1] == '0)
        else $error("flush left a valid line");
    chk_frozen_no_fill: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_13
        state == ST_LOOKUP && hit == 2'h0 && cache_freeze_in |=> state == ST_BYPASS)
        else $error("frozen cache allocated a line");
    chk_disabled_bypass: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_11
        state == ST_IDLE && fetch_req_in && !cache_enable_in |=> state == ST_BYPASS)
        else $error("disabled cache performed lookup");
    chk_lru_on_hit: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_10
        state == ST_LOOKUP && hit[0] && !cache_freeze_in |=> lru[$past(idx)] == 1'b1)
        else $error("LRU not pointing away from hit way");
    chk_fill_valid: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_12
        state == ST_FILL && ext_valid_in && cnt == LAST_WORD |=> valid[$past(victim)][$past(idx)] && fetch_done_out)
        else $error("filled line not marked valid");

    cov_dual_write: cover property (@(posedge clk_in) p_ok[0] && p_ok[1] && a_we_in && b_we_in);
    cov_hit: cover property (@(posedge clk_in) state == ST_LOOKUP && hit != 2'h0);
    cov_fill: cover property (@(posedge clk_in) state == ST_FILL && set_we);
    cov_bypass: cover property (@(posedge clk_in) state == ST_BYPASS && ext_valid_in);
endmodule : onchip_ram_and_icache

// ---- design/onchip_mem_pkg.sv ----
package onchip_mem_pkg;
    // Common byte address width of all requesters
    localparam int ADDR_W         = 24;
    // Dual-access RAM
    localparam int RAM_DW         = 16;
    localparam int BANK_COUNT     = 4;
    localparam int BANK_AW        = 12;
    localparam int BANK_SEL_LSB   = 13;
    localparam int BANK_SEL_W     = 2;
    localparam int WORD_LSB       = 1;
    localparam logic [ADDR_W-1:0] RAM_TOP_BYTE   = 24'h008000;
    localparam logic [ADDR_W-1:0] MAPPED_REG_END = 24'h0000C0;
    // Instruction cache
    localparam int CACHE_DW       = 32;
    localparam int SET_AW         = 9;
    localparam int WAY_COUNT      = 2;
    localparam int LINE_WORDS     = 4;
    localparam int WORD_SEL_W     = 2;
    localparam int WORD_SEL_LSB   = 2;
    localparam int SET_LSB        = 4;
    localparam int TAG_LSB        = 13;
    localparam int TAG_W          = ADDR_W - TAG_LSB;
    localparam int LINE_AW        = SET_AW + WORD_SEL_W;
    localparam logic [WORD_SEL_W-1:0] LAST_WORD = 2'h3;

    typedef enum logic [1:0] {SRC_PROGRAM, SRC_DATA, SRC_DMA, SRC_HOST} src_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_FILL, ST_BYPASS} cache_state_t;
endpackage : onchip_mem_pkg

// ---- design/dual_port_mem.sv ----
module dual_port_mem #(
    parameter int DW = 16,
    parameter int AW = 12
) (
    // Clock
    input  wire logic          clk_in,
    // Port A
    input  wire logic          a_en_in,
    input  wire logic          a_we_in,
    input  wire logic [AW-1:0] a_addr_in,
    input  wire logic [DW-1:0] a_wdata_in,
    output logic      [DW-1:0] a_rdata_out,
    // Port B
    input  wire logic          b_en_in,
    input  wire logic          b_we_in,
    input  wire logic [AW-1:0] b_addr_in,
    input  wire logic [DW-1:0] b_wdata_in,
    output logic      [DW-1:0] b_rdata_out
);
    logic [DW-1:0] mem [2**AW];

    // Two writes to one word: port B lands last
    always_ff @(posedge clk_in)
    begin
        if (a_en_in && a_we_in)
            mem[a_addr_in] <= a_wdata_in;
        if (b_en_in && b_we_in)
            mem[b_addr_in] <= b_wdata_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (a_en_in && !a_we_in)
            a_rdata_out <= mem[a_addr_in];
        if (b_en_in && !b_we_in)
            b_rdata_out <= mem[b_addr_in];
    end
endmodule : dual_port_mem

// ---- sim/ext_mem_model.sv ----
module ext_mem_model
    import onchip_mem_pkg::*;
(
    // Clock
    input  wire logic                clk_in,
    // Request side
    input  wire logic                ext_req_in,
    input  wire logic [ADDR_W-1:0]   ext_addr_in,
    input  wire logic [3:0]          delay_in,
    // Answer side
    output logic                     ext_valid_out,
    output logic     [CACHE_DW-1:0]  ext_data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    int wait_cnt;

    initial
    begin
        ext_valid_out = 1'b0;
        ext_data_out  = 32'h5A5A5A5A;
        wait_cnt      = 0;
    end

    // One word at a time while requested, each followed by a gap; data toggles while not valid
    always @(posedge clk_in)
    begin
        #1;
        if (ext_valid_out || !ext_req_in)
        begin
            ext_valid_out = 1'b0;
            ext_data_out  = ~ext_data_out;
            wait_cnt      = 0;
        end
        else if (wait_cnt >= delay_in)
        begin
            ext_valid_out = 1'b1;
            ext_data_out  = {8'hC3, ext_addr_in};
        end
        else
        begin
            wait_cnt++;
            ext_data_out = ~ext_data_out;
        end
    end
endmodule : ext_mem_model

// ---- sim/onchip_ram_and_icache_tb_top.sv ----
module onchip_ram_and_icache_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import onchip_mem_pkg::*;

    logic clk_in, reset_in, device_in_reset_in;
    logic a_req_in, a_we_in, a_ack_out, a_err_out;
    logic b_req_in, b_we_in, b_ack_out, b_err_out;
    src_t a_src_in, b_src_in;
    logic [ADDR_W-1:0] a_addr_in, b_addr_in, fetch_addr_in, ext_addr_out;
    logic [RAM_DW-1:0] a_wdata_in, b_wdata_in, a_rdata_out, b_rdata_out;
    logic cache_enable_in, cache_freeze_in, cache_flush_in;
    logic fetch_req_in, fetch_busy_out, fetch_done_out, ext_req_out, ext_valid_in;
    logic [CACHE_DW-1:0] fetch_data_out, ext_data_in;
    logic [3:0] delay;
    logic [ADDR_W-1:0] seen[$];
    int miscompares = 0;
    int n_tests = 0;

    onchip_ram_and_icache onchip_ram_and_icache_inst (
        .clk_in(clk_in), .reset_in(reset_in), .device_in_reset_in(device_in_reset_in),
        .a_req_in(a_req_in), .a_we_in(a_we_in), .a_src_in(a_src_in), .a_addr_in(a_addr_in),
        .a_wdata_in(a_wdata_in), .a_rdata_out(a_rdata_out), .a_ack_out(a_ack_out), .a_err_out(a_err_out),
        .b_req_in(b_req_in), .b_we_in(b_we_in), .b_src_in(b_src_in), .b_addr_in(b_addr_in),
        .b_wdata_in(b_wdata_in), .b_rdata_out(b_rdata_out), .b_ack_out(b_ack_out), .b_err_out(b_err_out),
        .cache_enable_in(cache_enable_in), .cache_freeze_in(cache_freeze_in), .cache_flush_in(cache_flush_in),
        .fetch_req_in(fetch_req_in), .fetch_addr_in(fetch_addr_in), .fetch_busy_out(fetch_busy_out),
        .fetch_done_out(fetch_done_out), .fetch_data_out(fetch_data_out), .ext_req_out(ext_req_out),
        .ext_addr_out(ext_addr_out), .ext_valid_in(ext_valid_in), .ext_data_in(ext_data_in));

    ext_mem_model ext_mem_model_inst (
        .clk_in(clk_in), .ext_req_in(ext_req_out), .ext_addr_in(ext_addr_out), .delay_in(delay),
        .ext_valid_out(ext_valid_in), .ext_data_out(ext_data_in));

    initial clk_in = 1'b0;
    always #5 clk_in = ~clk_in;

    // Addresses of words handed over by external memory
    always @(negedge clk_in)
        if (ext_valid_in === 1'b1)
            seen.push_back(ext_addr_out);

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic step;
        @(posedge clk_in);
        #1;
    endtask : step

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic ram_set(input bit port, input logic req, input logic we, input src_t src,
                           input logic [23:0] addr, input logic [15:0] wd);
        if (port == 1'b0)
        begin
            {a_req_in, a_we_in, a_addr_in, a_wdata_in} = {req, we, addr, wd};
            a_src_in = src;
        end
        else
        begin
            {b_req_in, b_we_in, b_addr_in, b_wdata_in} = {req, we, addr, wd};
            b_src_in = src;
        end
    endtask : ram_set

    task automatic ram_done(input logic [1:0] ea, input logic [15:0] da, input logic [1:0] eb,
                            input logic [15:0] db, input bit rd_a, input bit rd_b);
        step;
        check(32'({a_ack_out, a_err_out}), 32'(ea));
        check(32'({b_ack_out, b_err_out}), 32'(eb));
        if (rd_a)
            check(32'(a_rdata_out), 32'(da));
        if (rd_b)
            check(32'(b_rdata_out), 32'(db));
    endtask : ram_done

    function automatic logic [23:0] lo(input int i);
        return 24'(i * 32'h2000 + 32'h00C0);
    endfunction : lo

    function automatic logic [23:0] hi(input int i);
        return 24'(i * 32'h2000 + 32'h1FFE);
    endfunction : hi

    task automatic t_banks;
        for (int i = 0; i < 4; i++)
        begin
            ram_set(0, 1, 1, src_t'(i % 3), lo(i), 16'(32'hA000 + i));
            ram_set(1, 1, 1, SRC_DMA, hi(i), 16'(32'h5000 + i));
            ram_done(2'h2, 16'h0, 2'h2, 16'h0, 0, 0);
        end
        for (int i = 0; i < 4; i++)
        begin
            ram_set(0, 1, 0, SRC_PROGRAM, hi(i), 16'h0);
            ram_set(1, 1, 0, SRC_DATA, lo(i), 16'h0);
            ram_done(2'h2, 16'(32'h5000 + i), 2'h2, 16'(32'hA000 + i), 1, 1);
        end
        // Write and read in one bank in the same cycle
        ram_set(0, 1, 1, SRC_DATA, lo(0), 16'h7E11);
        ram_set(1, 1, 0, SRC_DMA, hi(0), 16'h0);
        ram_done(2'h2, 16'h0, 2'h2, 16'h5000, 0, 1);
        $display("t_banks finished");
    endtask : t_banks

    task automatic t_refuse;
        ram_set(0, 1, 1, SRC_DATA, 24'h000200, 16'h1234);
        ram_set(1, 1, 1, SRC_DATA, 24'h0080C0, 16'hBAD0);
        ram_done(2'h2, 16'h0, 2'h1, 16'h0, 0, 0);
        device_in_reset_in = 1'b1;
        ram_set(0, 1, 1, SRC_HOST, 24'h000200, 16'hDEAD);
        ram_set(1, 1, 0, SRC_DATA, 24'h000200, 16'h0);
        ram_done(2'h1, 16'h0, 2'h2, 16'h1234, 0, 1);
        device_in_reset_in = 1'b0;
        ram_set(0, 1, 0, SRC_HOST, 24'h000200, 16'h0);
        ram_set(1, 1, 0, SRC_DATA, 24'h0000C0, 16'h0);
        ram_done(2'h2, 16'h1234, 2'h2, 16'h7E11, 1, 1);
        ram_set(0, 1, 0, SRC_DMA, 24'h007FFE, 16'h0);
        ram_set(1, 1, 0, SRC_DATA, 24'h0000BE, 16'h0);
        ram_done(2'h2, 16'h5003, 2'h1, 16'h0, 1, 0);
        ram_set(0, 1, 0, SRC_DATA, 24'h008000, 16'h0);
        ram_set(1, 1, 1, SRC_DATA, 24'h000000, 16'hBEEF);
        ram_done(2'h1, 16'h0, 2'h1, 16'h0, 0, 0);
        ram_set(0, 0, 0, SRC_DATA, 24'h0, 16'h0);
        ram_set(1, 0, 0, SRC_DATA, 24'h0, 16'h0);
        $display("t_refuse finished");
    endtask : t_refuse

    function automatic logic [23:0] mk(input int tag, input int w);
        return {11'(tag), 9'h015, 2'(w), 2'b00};
    endfunction : mk

    task automatic fetch(input logic [23:0] addr, input int exp_words, input int exp_lat);
        int n;
        seen.delete();
        fetch_req_in  = 1'b1;
        fetch_addr_in = addr;
        step;
        fetch_req_in = 1'b0;
        check(32'(fetch_busy_out), 32'h1);
        // Take cycle counts as the first
        n = 1;
        while (fetch_done_out !== 1'b1 && n < 200)
        begin
            step;
            n++;
        end
        check(32'(fetch_done_out), 32'h1);
        check(32'(fetch_busy_out), 32'h0);
        check(fetch_data_out, {8'hC3, addr[23:2], 2'b00});
        check(32'(seen.size()), 32'(exp_words));
        for (int k = 0; k < seen.size(); k++)
            check(32'(seen[k]), exp_words == 4 ? 32'({addr[23:4], 2'(k), 2'b00}) : 32'({addr[23:2], 2'b00}));
        if (exp_lat > 0)
            check(32'(n), 32'(exp_lat));
    endtask : fetch

    task automatic t_cache;
        cache_enable_in = 1'b1;
        fetch(mk(1, 2), 4, 0);
        fetch(mk(1, 1), 0, 2);
        delay = 4'h3;
        fetch(mk(2, 0), 4, 0);
        fetch(mk(1, 0), 0, 2);
        fetch(mk(3, 1), 4, 0);
        fetch(mk(1, 2), 0, 2);
        fetch(mk(3, 3), 0, 2);
        fetch(mk(2, 0), 4, 0);
        fetch(mk(3, 0), 0, 2);
        delay = 4'h0;
        fetch(mk(1, 0), 4, 0);
        $display("t_cache finished");
    endtask : t_cache

    task automatic t_controls;
        cache_freeze_in = 1'b1;
        fetch(mk(2, 1), 1, 0);
        fetch(mk(2, 1), 1, 0);
        fetch(mk(1, 3), 0, 2);
        cache_freeze_in = 1'b0;
        cache_flush_in  = 1'b1;
        step;
        cache_flush_in = 1'b0;
        fetch(mk(1, 3), 4, 0);
        fetch(mk(3, 0), 4, 0);
        cache_enable_in = 1'b0;
        fetch(mk(1, 3), 1, 0);
        $display("t_controls finished");
    endtask : t_controls

    initial
    begin
        {reset_in, device_in_reset_in, delay} = {1'b1, 1'b1, 4'h0};
        ram_set(0, 0, 0, SRC_PROGRAM, 24'h0, 16'h0);
        ram_set(1, 0, 0, SRC_PROGRAM, 24'h0, 16'h0);
        {cache_enable_in, cache_freeze_in, cache_flush_in, fetch_req_in, fetch_addr_in} = '0;
        repeat (16) @(posedge clk_in);
        #1;
        reset_in           = 1'b0;
        device_in_reset_in = 1'b0;
        t_banks;
        t_refuse;
        t_cache;
        t_controls;
        tally_and_finish;
    end

    // Watchdog well beyond the expected run of under two hundred cycles
    initial
    begin
        #100us;
        miscompares++;
        tally_and_finish;
    end
endmodule : onchip_ram_and_icache_tb_top
